// [rtl/gfm_monitor.sv]
// gas flow limit monitor top: limits, relay, peak, usage log, cylinder volume, avalon slave
// What this block does
// - relay closed while flow inside limits
// - relay opens when flow leaves band
// - no high fault before delay expires
// - delay 0.5 to 10.0 s from flow start
// - after delay, below low limit opens relay
// - high limit 5-255, alarm and peak threshold
// - above high: update peak, count time
// - peak and time cleared at flow start
// - alarms off: relay open, no testing
// - log on accumulates volume and flow time
// - time clear zeroes flow timer
// - volume clear zeroes volume total
// - unit select: set LPM, clear CFH
// - unique station address 1 to 247
// - smoothing affects only displayed rate
// - analog output 0.01 V per unit
// - remaining volume below minimum raises fault
// - start volume zero disables volume fault
// - volume fault sets coil, not relay
// - volume total wraps to zero past maximum
//
// Added by the designer: the Avalon-MM slave port and the register offsets.
module gfm_monitor
   import gfm_pkg::*;
#(
   parameter int CYCLES_PER_TICK = TICK_CYCLES
) (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // avalon-mm slave
   input wire logic [7:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // sensor
   input wire logic [7:0] i_flow_rate,
   // relay, coil, analog, display, units, station address
   output logic o_relay_contact_one,
   output logic o_relay_contact_two,
   output logic o_low_volume_coil,
   output logic [7:0] o_analog_code,
   output logic [7:0] o_display_rate,
   output logic o_metric_units,
   output logic [7:0] o_bus_station_address
);
   // =====================================================
   // time base and smoothing
   logic tick;
   logic [7:0] smooth_rate;
   logic [7:0] smooth_tc_q;

   gfm_tick #(
      .CYCLES(CYCLES_PER_TICK)
   ) u_tick (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .o_tick(tick)
   );

   // smoothing sees the raw rate, only the display uses its output
   gfm_smooth u_smooth (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_tick(tick),
      .i_tc(smooth_tc_q),
      .i_rate(i_flow_rate),
      .o_rate(smooth_rate)
   );

   // =====================================================
   // settings registers
   logic alarm_en_q;
   logic log_en_q;
   logic metric_q;
   logic [7:0] high_q;
   logic [7:0] low_q;
   logic [7:0] delay_q;
   logic [7:0] station_q;
   logic [15:0] start_vol_q;
   logic [15:0] min_vol_q;

   // bus decode
   logic wq_q;
   logic take;
   logic wr_en;
   logic [7:0] wv;
   logic ctrl_wr;
   logic clr_time;
   logic clr_vol;
   logic start_wr;
   assign take = (i_avs_read || i_avs_write) && !wq_q;
   assign wr_en = take && i_avs_write;
   assign wv = i_avs_writedata[7:0];
   assign ctrl_wr = wr_en && (i_avs_address == REG_CTRL);
   assign clr_time = ctrl_wr && i_avs_writedata[CTRL_CLR_TIME];
   assign clr_vol = ctrl_wr && i_avs_writedata[CTRL_CLR_VOL];
   assign start_wr = wr_en && (i_avs_address == REG_START_VOL);

   // range checks: out-of-range writes are ignored
   logic high_ok;
   logic low_ok;
   logic delay_ok;
   logic station_ok;
   logic smooth_ok;
   assign high_ok = (wv >= HIGH_MIN) && (wv <= HIGH_MAX);
   assign low_ok = (wv >= LOW_MIN) && (wv <= LOW_MAX);
   assign delay_ok = (wv >= DELAY_MIN) && (wv <= DELAY_MAX);
   assign station_ok = (wv >= STATION_MIN) && (wv <= STATION_MAX);
   assign smooth_ok = (wv >= SMOOTH_MIN);

   // settings storage
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         alarm_en_q <= 1'b0;
         log_en_q <= 1'b0;
         metric_q <= 1'b0;
         high_q <= HIGH_RESET;
         low_q <= LOW_RESET;
         delay_q <= DELAY_RESET;
         station_q <= STATION_RESET;
         smooth_tc_q <= SMOOTH_RESET;
         start_vol_q <= 16'h0000;
         min_vol_q <= 16'h0000;
      end else if (wr_en) begin
         if (i_avs_address == REG_CTRL) begin
            alarm_en_q <= i_avs_writedata[CTRL_ALARM_EN];
            log_en_q <= i_avs_writedata[CTRL_LOG_EN];
            metric_q <= i_avs_writedata[CTRL_METRIC];
         end
         if (i_avs_address == REG_HIGH_LIMIT && high_ok) begin
            high_q <= wv;
         end
         if (i_avs_address == REG_LOW_LIMIT && low_ok) begin
            low_q <= wv;
         end
         if (i_avs_address == REG_TEST_DELAY && delay_ok) begin
            delay_q <= wv;
         end
         if (i_avs_address == REG_STATION && station_ok) begin
            station_q <= wv;
         end
         if (i_avs_address == REG_SMOOTH && smooth_ok) begin
            smooth_tc_q <= wv;
         end
         if (start_wr) begin
            start_vol_q <= i_avs_writedata[15:0];
         end
         if (i_avs_address == REG_MIN_VOL) begin
            min_vol_q <= i_avs_writedata[15:0];
         end
      end
   end

   // =====================================================
   // flow period detection
   logic flowing;
   logic flow_q;
   logic flow_start;
   assign flowing = (i_flow_rate > FLOW_DETECT);
   assign flow_start = flowing && !flow_q;

   // =====================================================
   // limit-check state machine and delay timer
   gfm_state_t state_q;
   gfm_state_t state_d;
   logic [7:0] dly_cnt_q;
   logic [7:0] dly_cnt_d;
   logic dly_done;
   assign dly_done = (dly_cnt_q >= delay_q);

   // next state: delay runs from the first detection of flow
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         GFM_IDLE: begin
            if (flowing) begin
               state_d = GFM_DELAY;
            end
         end
         GFM_DELAY: begin
            if (!flowing) begin
               state_d = GFM_IDLE;
            end else if (dly_done) begin
               state_d = GFM_TEST;
            end
         end
         GFM_TEST: begin
            if (!flowing) begin
               state_d = GFM_IDLE;
            end
         end
         default: begin
            state_d = GFM_IDLE;
         end
      endcase
   end

   // delay counter in tenths of a second
   assign dly_cnt_d = (state_q == GFM_IDLE) ? 8'h00 :
                      (tick && !dly_done) ? dly_cnt_q + 8'h01 : dly_cnt_q;

   // relay decision
   logic in_band;
   logic above_high;
   logic relay_d;
   assign above_high = (i_flow_rate > high_q);
   assign in_band = (i_flow_rate >= low_q) && !above_high;
   assign relay_d = alarm_en_q && flowing &&
                    ((state_q != GFM_TEST) || in_band);

   // state, delay and relay registers
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         state_q <= GFM_IDLE;
         dly_cnt_q <= 8'h00;
         flow_q <= 1'b0;
         o_relay_contact_one <= 1'b0;
         o_relay_contact_two <= 1'b0;
      end else begin
         state_q <= state_d;
         dly_cnt_q <= dly_cnt_d;
         flow_q <= flowing;
         o_relay_contact_one <= relay_d;
         o_relay_contact_two <= relay_d;
      end
   end

   // =====================================================
   // surge peak and time above the high limit
   logic [7:0] peak_q;
   logic [15:0] above_q;
   logic [7:0] peak_d;
   logic [15:0] above_d;
   assign peak_d = flow_start ? 8'h00 :
                   (above_high && i_flow_rate > peak_q) ? i_flow_rate : peak_q;
   assign above_d = flow_start ? 16'h0000 :
                    (above_high && tick) ? above_q + 16'h0001 : above_q;

   // peak registers
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         peak_q <= 8'h00;
         above_q <= 16'h0000;
      end else begin
         peak_q <= peak_d;
         above_q <= above_d;
      end
   end

   // =====================================================
   // volume integration on the raw rate
   logic [15:0] frac_q;
   logic [15:0] frac_sum;
   logic [15:0] frac_lim;
   logic tenth;
   assign frac_lim = metric_q ? FRAC_PER_TENTH_LPM : FRAC_PER_TENTH_CFH;
   assign frac_sum = frac_q + {8'h00, i_flow_rate};
   assign tenth = tick && flowing && (frac_sum >= frac_lim);

   // usage log volume total
   logic [15:0] vol_q;
   logic [15:0] vol_d;
   assign vol_d = clr_vol ? 16'h0000 :
                  !(tenth && log_en_q) ? vol_q :
                  (vol_q >= VOLUME_MAX) ? 16'h0000 : vol_q + 16'h0001;

   // cylinder usage restarts whenever a new start volume is written
   logic [15:0] used_q;
   logic [15:0] used_d;
   logic [15:0] remain;
   assign used_d = start_wr ? 16'h0000 :
                   (tenth && used_q != 16'hFFFF) ? used_q + 16'h0001 : used_q;
   assign remain = (used_q >= start_vol_q) ? 16'h0000 : start_vol_q - used_q;

   // integration registers
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         frac_q <= 16'h0000;
         vol_q <= 16'h0000;
         used_q <= 16'h0000;
      end else begin
         if (tick && flowing) begin
            frac_q <= tenth ? frac_sum - frac_lim : frac_sum;
         end
         vol_q <= vol_d;
         used_q <= used_d;
      end
   end

   // =====================================================
   // total flow time as hours, minutes, seconds
   logic [3:0] sub_q;
   logic [5:0] sec_q;
   logic [5:0] min_q;
   logic [7:0] hr_q;
   logic time_run;
   logic sec_wrap;
   logic min_wrap;
   logic sub_wrap;
   assign time_run = tick && flowing && log_en_q;
   assign sub_wrap = (sub_q == TICKS_PER_SEC - 4'h1);
   assign sec_wrap = sub_wrap && (sec_q == SEC_PER_MIN - 6'h01);
   assign min_wrap = sec_wrap && (min_q == SEC_PER_MIN - 6'h01);

   // flow timer
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         sub_q <= 4'h0;
         sec_q <= 6'h00;
         min_q <= 6'h00;
         hr_q <= 8'h00;
      end else if (clr_time) begin
         sub_q <= 4'h0;
         sec_q <= 6'h00;
         min_q <= 6'h00;
         hr_q <= 8'h00;
      end else if (time_run) begin
         sub_q <= sub_wrap ? 4'h0 : sub_q + 4'h1;
         if (sub_wrap) begin
            sec_q <= sec_wrap ? 6'h00 : sec_q + 6'h01;
         end
         if (sec_wrap) begin
            min_q <= min_wrap ? 6'h00 : min_q + 6'h01;
         end
         if (min_wrap) begin
            hr_q <= (hr_q == HOURS_WRAP - 8'h01) ? 8'h00 : hr_q + 8'h01;
         end
      end
   end

   // =====================================================
   // low cylinder volume coil, kept apart from the relay
   logic low_vol;
   assign low_vol = (start_vol_q != 16'h0000) && (remain < min_vol_q);

   // output registers
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_low_volume_coil <= 1'b0;
         o_analog_code <= 8'h00;
         o_display_rate <= 8'h00;
         o_metric_units <= 1'b0;
         o_bus_station_address <= STATION_RESET;
      end else begin
         o_low_volume_coil <= low_vol;
         o_analog_code <= i_flow_rate;
         o_display_rate <= smooth_rate;
         o_metric_units <= metric_q;
         o_bus_station_address <= station_q;
      end
   end

   // =====================================================
   // read mux, unmapped addresses read zero
   logic [31:0] rd_mux;
   logic [31:0] status_word;
   assign status_word = {26'h0, low_vol, o_relay_contact_one, state_q, flow_q, dly_done};
   assign rd_mux =
      (i_avs_address == REG_CTRL) ? {29'h0, metric_q, log_en_q, alarm_en_q} :
      (i_avs_address == REG_HIGH_LIMIT) ? {24'h0, high_q} :
      (i_avs_address == REG_LOW_LIMIT) ? {24'h0, low_q} :
      (i_avs_address == REG_TEST_DELAY) ? {24'h0, delay_q} :
      (i_avs_address == REG_STATION) ? {24'h0, station_q} :
      (i_avs_address == REG_SMOOTH) ? {24'h0, smooth_tc_q} :
      (i_avs_address == REG_START_VOL) ? {16'h0, start_vol_q} :
      (i_avs_address == REG_MIN_VOL) ? {16'h0, min_vol_q} :
      (i_avs_address == REG_STATUS) ? status_word :
      (i_avs_address == REG_PEAK) ? {24'h0, peak_q} :
      (i_avs_address == REG_TIME_ABOVE) ? {16'h0, above_q} :
      (i_avs_address == REG_VOLUME) ? {16'h0, vol_q} :
      (i_avs_address == REG_FLOW_TIME) ? {8'h0, hr_q, 2'h0, min_q, 2'h0, sec_q} :
      (i_avs_address == REG_DISPLAY) ? {24'h0, smooth_rate} :
      (i_avs_address == REG_REMAIN) ? {16'h0, remain} : 32'h0;

   // fixed two-cycle slave: waitrequest drops one cycle after the request
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         wq_q <= 1'b1;
         o_avs_waitrequest <= 1'b1;
         o_avs_readdata <= 32'h0;
      end else begin
         wq_q <= !((i_avs_read || i_avs_write) && wq_q);
         o_avs_waitrequest <= !((i_avs_read || i_avs_write) && wq_q);
         if ((i_avs_read || i_avs_write) && wq_q) begin
            o_avs_readdata <= rd_mux;
         end
      end
   end
endmodule : gfm_monitor

// [rtl/gfm_pkg.sv]
// shared constants for the gas flow limit monitor
package gfm_pkg;
   // =====================================================
   // clock and time base
   localparam int CLK_PERIOD_NS = 8;
   localparam int TICK_TIME_MS = 100;
   localparam int TICK_CYCLES = (TICK_TIME_MS * 1000000) / CLK_PERIOD_NS;
   localparam logic [3:0] TICKS_PER_SEC = 4'hA;
   localparam logic [5:0] SEC_PER_MIN = 6'h3C;
   localparam logic [7:0] HOURS_WRAP = 8'h64;

   // =====================================================
   // register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_HIGH_LIMIT = 8'h04;
   localparam logic [7:0] REG_LOW_LIMIT = 8'h08;
   localparam logic [7:0] REG_TEST_DELAY = 8'h0C;
   localparam logic [7:0] REG_STATION = 8'h10;
   localparam logic [7:0] REG_SMOOTH = 8'h14;
   localparam logic [7:0] REG_START_VOL = 8'h18;
   localparam logic [7:0] REG_MIN_VOL = 8'h1C;
   localparam logic [7:0] REG_STATUS = 8'h20;
   localparam logic [7:0] REG_PEAK = 8'h24;
   localparam logic [7:0] REG_TIME_ABOVE = 8'h28;
   localparam logic [7:0] REG_VOLUME = 8'h2C;
   localparam logic [7:0] REG_FLOW_TIME = 8'h30;
   localparam logic [7:0] REG_DISPLAY = 8'h34;
   localparam logic [7:0] REG_REMAIN = 8'h38;

   // =====================================================
   // control register bit positions
   localparam int CTRL_ALARM_EN = 0;
   localparam int CTRL_LOG_EN = 1;
   localparam int CTRL_METRIC = 2;
   localparam int CTRL_CLR_TIME = 3;
   localparam int CTRL_CLR_VOL = 4;

   // =====================================================
   // ranges and reset values
   localparam logic [7:0] HIGH_MIN = 8'h05;
   localparam logic [7:0] HIGH_MAX = 8'hFF;
   localparam logic [7:0] LOW_MIN = 8'h05;
   localparam logic [7:0] LOW_MAX = 8'h64;
   localparam logic [7:0] DELAY_MIN = 8'h05;
   localparam logic [7:0] DELAY_MAX = 8'h64;
   localparam logic [7:0] STATION_MIN = 8'h01;
   localparam logic [7:0] STATION_MAX = 8'hF7;
   localparam logic [7:0] SMOOTH_MIN = 8'h01;
   localparam logic [7:0] HIGH_RESET = 8'h32;
   localparam logic [7:0] LOW_RESET = 8'h0A;
   localparam logic [7:0] DELAY_RESET = 8'h0A;
   localparam logic [7:0] STATION_RESET = 8'h01;
   localparam logic [7:0] SMOOTH_RESET = 8'h01;
   localparam logic [7:0] FLOW_DETECT = 8'h03;

   // =====================================================
   // volume integration (tenths of a unit per 100 ms tick)
   localparam logic [15:0] FRAC_PER_TENTH_CFH = 16'h0E10;
   localparam logic [15:0] FRAC_PER_TENTH_LPM = 16'h003C;
   localparam logic [15:0] VOLUME_MAX = 16'hFFDC;

   // relay state
   typedef enum logic [1:0] {
      GFM_IDLE = 2'b00,
      GFM_DELAY = 2'b01,
      GFM_TEST = 2'b10
   } gfm_state_t;
endpackage : gfm_pkg

// [rtl/gfm_smooth.sv]
// display-only smoothing of the flow rate
module gfm_smooth
   import gfm_pkg::*;
(
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // time base and setting
   input wire logic i_tick,
   input wire logic [7:0] i_tc,
   // rate in and smoothed rate out
   input wire logic [7:0] i_rate,
   output logic [7:0] o_rate
);
   // =====================================================
   // step halfway toward the raw rate once every tc ticks
   logic [7:0] cnt_q;
   logic [7:0] cnt_d;
   logic [7:0] y_d;
   logic [7:0] up_step;
   logic [7:0] dn_step;
   logic step;
   assign step = i_tick && (cnt_q + 8'h01 >= i_tc);
   assign cnt_d = !i_tick ? cnt_q : (step ? 8'h00 : cnt_q + 8'h01);
   assign up_step = ((i_rate - o_rate) >> 1) | 8'h01;
   assign dn_step = ((o_rate - i_rate) >> 1) | 8'h01;
   assign y_d = !step ? o_rate :
                (i_rate > o_rate) ? o_rate + up_step :
                (i_rate < o_rate) ? o_rate - dn_step : o_rate;

   // filter state
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt_q <= 8'h00;
         o_rate <= 8'h00;
      end else begin
         cnt_q <= cnt_d;
         o_rate <= y_d;
      end
   end
endmodule : gfm_smooth

// [rtl/gfm_tick.sv]
// free-running 100 ms time-base divider
module gfm_tick
   import gfm_pkg::*;
#(
   parameter int CYCLES = TICK_CYCLES
) (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // tick out
   output logic o_tick
);
   // =====================================================
   // divider
   logic [31:0] cnt_q;
   logic [31:0] cnt_d;
   logic wrap;
   assign wrap = (cnt_q == 32'(CYCLES - 1));
   assign cnt_d = wrap ? 32'h0 : cnt_q + 32'h1;

   // count and pulse
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt_q <= 32'h0;
         o_tick <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         o_tick <= wrap;
      end
   end
endmodule : gfm_tick

// [sim/gfm_gas_line.sv]
// gas line model feeding the flow sensor input
module gfm_gas_line (
   // clock
   input wire logic i_sys_clk,
   // commanded flow and sensed rate
   input wire logic [7:0] i_target,
   output logic [7:0] o_flow_rate
);
   timeunit 1ns;
   timeprecision 1ps;
   // =====================================================
   // rate follows the valve one edge later, zero at rest
   initial o_flow_rate = 8'h00;
   always @(posedge i_sys_clk) begin
      o_flow_rate <= i_target;
   end
endmodule : gfm_gas_line

// [sim/gfm_monitor_assertions.sv]
// port checker for the gas flow limit monitor
module gfm_monitor_checker
   import gfm_pkg::*;
#(
   parameter int CYCLES_PER_TICK = TICK_CYCLES
) (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // bus and sensor
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [7:0] i_flow_rate,
   // outputs watched
   input wire logic o_avs_waitrequest,
   input wire logic o_relay_contact_one,
   input wire logic o_relay_contact_two,
   input wire logic [7:0] o_analog_code,
   input wire logic o_metric_units,
   input wire logic [7:0] o_bus_station_address
);
   timeunit 1ns;
   timeprecision 1ps;
   // =====================================================
   // one clock domain
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_rst);

   contacts_same_a: assert property (o_relay_contact_one == o_relay_contact_two)
      else $error("relay contacts disagree");
   analog_rate_a: assert property (!$past(i_rst) |-> o_analog_code == $past(i_flow_rate))
      else $error("analog code not the raw rate");
   noflow_open_a: assert property ((i_flow_rate <= FLOW_DETECT) [*2] |=> !o_relay_contact_one)
      else $error("relay closed without flow");
   wait_short_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("waitrequest low too long");
   answer_next_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
      else $error("bus answer late");
   station_range_a: assert property (o_bus_station_address >= STATION_MIN && o_bus_station_address <= STATION_MAX)
      else $error("station address out of range");
   station_hold_a: assert property (!$past(i_avs_write && !o_avs_waitrequest) |=> $stable(o_bus_station_address))
      else $error("station changed without write");
   metric_hold_a: assert property (!$past(i_avs_write && !o_avs_waitrequest) |=> $stable(o_metric_units))
      else $error("unit select changed without write");
endmodule : gfm_monitor_checker

bind gfm_monitor gfm_monitor_checker #(.CYCLES_PER_TICK(CYCLES_PER_TICK)) u_chk (
   .i_sys_clk(i_sys_clk),
   .i_rst(i_rst),
   .i_avs_read(i_avs_read),
   .i_avs_write(i_avs_write),
   .i_flow_rate(i_flow_rate),
   .o_avs_waitrequest(o_avs_waitrequest),
   .o_relay_contact_one(o_relay_contact_one),
   .o_relay_contact_two(o_relay_contact_two),
   .o_analog_code(o_analog_code),
   .o_metric_units(o_metric_units),
   .o_bus_station_address(o_bus_station_address)
);

// [sim/gfm_monitor_tb_top.sv]
// self-checking bench for the gas flow limit monitor
module gfm_monitor_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import gfm_pkg::*;
   // =====================================================
   // signals
   logic i_sys_clk = 1'b0;
   logic i_rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic rd_en = 1'b0;
   logic wr_en = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [7:0] target = 8'h00;
   logic [7:0] flow, disp, station;
   logic [31:0] rdata, rd;
   logic wreq, relay, coil, metric;
   int n_mismatch = 0;
   int checked = 0;

   // clock, 8 ns
   always #4 i_sys_clk = ~i_sys_clk;

   // short tick keeps delays at tens of cycles
   gfm_monitor #(.CYCLES_PER_TICK(10)) dut (
      .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_avs_address(addr), .i_avs_read(rd_en),
      .i_avs_write(wr_en), .i_avs_writedata(wdata), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
      .i_flow_rate(flow), .o_relay_contact_one(relay), .o_relay_contact_two(), .o_low_volume_coil(coil),
      .o_analog_code(), .o_display_rate(disp), .o_metric_units(metric), .o_bus_station_address(station));
   gfm_gas_line u_line (.i_sys_clk(i_sys_clk), .i_target(target), .o_flow_rate(flow));

   // =====================================================
   // helpers
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : stop_test

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask : check

   // one avalon transfer, held until waitrequest low
   task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_sys_clk);
      addr <= a;
      wdata <= d;
      wr_en <= we;
      rd_en <= !we;
      do begin
         @(posedge i_sys_clk);
      end while (wreq !== 1'b0);
      rd = rdata;
      wr_en <= 1'b0;
      rd_en <= 1'b0;
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      xfer(1'b1, a, {24'h0, d});
   endtask : wr

   task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
      xfer(1'b0, a, 32'h0);
      check(nm, rd, {24'h0, e});
   endtask : rdc

   task automatic cyc(input int n);
      repeat (n) @(posedge i_sys_clk);
   endtask : cyc

   // =====================================================
   // scenarios
   // reset values, unmapped read, refused settings
   task automatic t_regs;
      rdc("high", REG_HIGH_LIMIT, HIGH_RESET);
      rdc("low", REG_LOW_LIMIT, LOW_RESET);
      rdc("delay", REG_TEST_DELAY, DELAY_RESET);
      rdc("smooth", REG_SMOOTH, SMOOTH_RESET);
      rdc("unmapped", 8'h3C, 8'h00);
      check("station_rst", station, 32'h1);
      wr(REG_HIGH_LIMIT, 8'h04);
      rdc("high_low_edge", REG_HIGH_LIMIT, HIGH_RESET);
      wr(REG_LOW_LIMIT, 8'h65);
      rdc("low_over", REG_LOW_LIMIT, LOW_RESET);
      wr(REG_TEST_DELAY, 8'h04);
      rdc("delay_under", REG_TEST_DELAY, DELAY_RESET);
      wr(REG_TEST_DELAY, 8'h05);
      rdc("delay_min", REG_TEST_DELAY, 8'h05);
      wr(REG_STATION, 8'hF8);
      cyc(2);
      check("station_over", station, 32'h1);
      wr(REG_STATION, 8'hF7);
      cyc(2);
      check("station_max", station, 32'hF7);
   endtask : t_regs

   // limits, delay, peak capture and clearing
   task automatic t_limits;
      wr(REG_CTRL, 8'h01);
      target <= 8'd60;
      cyc(30);
      check("relay_in_delay", relay, 32'h1);
      cyc(50);
      check("relay_high", relay, 32'h0);
      rdc("peak", REG_PEAK, 8'd60);
      xfer(1'b0, REG_TIME_ABOVE, 32'h0);
      check("above_count", rd == 32'h0, 32'h0);
      target <= 8'd30;
      cyc(5);
      check("relay_band", relay, 32'h1);
      target <= 8'd7;
      cyc(5);
      check("relay_low", relay, 32'h0);
      target <= 8'd0;
      cyc(5);
      target <= 8'd30;
      cyc(5);
      rdc("peak_clr", REG_PEAK, 8'h00);
      rdc("above_clr", REG_TIME_ABOVE, 8'h00);
      wr(REG_CTRL, 8'h00);
      cyc(80);
      check("relay_alarm_off", relay, 32'h0);
      target <= 8'd0;
   endtask : t_limits

   // usage log, clears, units and display smoothing
   task automatic t_log;
      wr(REG_CTRL, 8'h1E);
      cyc(2);
      check("metric_on", metric, 32'h1);
      target <= 8'd60;
      cyc(200);
      check("display", disp, 32'd60);
      target <= 8'd0;
      cyc(5);
      xfer(1'b0, REG_VOLUME, 32'h0);
      check("volume", rd >= 32'd18 && rd <= 32'd21, 32'h1);
      xfer(1'b0, REG_FLOW_TIME, 32'h0);
      check("flow_sec", rd[5:0] >= 6'd1 && rd[5:0] <= 6'd2, 32'h1);
      wr(REG_CTRL, 8'h16);
      rdc("vol_clr", REG_VOLUME, 8'h00);
      wr(REG_CTRL, 8'h0E);
      rdc("time_clr", REG_FLOW_TIME, 8'h00);
      wr(REG_CTRL, 8'h04);
      target <= 8'd60;
      cyc(100);
      target <= 8'd0;
      rdc("vol_log_off", REG_VOLUME, 8'h00);
      wr(REG_CTRL, 8'h00);
      cyc(2);
      check("metric_off", metric, 32'h0);
   endtask : t_log

   // cylinder volume fault on the coil only
   task automatic t_coil;
      wr(REG_START_VOL, 8'd10);
      wr(REG_MIN_VOL, 8'd8);
      wr(REG_HIGH_LIMIT, 8'hFF);
      wr(REG_LOW_LIMIT, 8'h05);
      wr(REG_CTRL, 8'h07);
      check("coil_full", coil, 32'h0);
      target <= 8'd60;
      cyc(60);
      check("coil_low", coil, 32'h1);
      check("relay_kept", relay, 32'h1);
      target <= 8'd0;
      wr(REG_START_VOL, 8'h00);
      cyc(2);
      check("coil_off", coil, 32'h0);
   endtask : t_coil

   // =====================================================
   // main sequence and watchdog
   initial begin
      cyc(5);
      i_rst <= 1'b0;
      t_regs();
      t_limits();
      t_log();
      t_coil();
      stop_test();
   end

   initial begin
      cyc(20000);
      n_mismatch++;
      stop_test();
   end
endmodule : gfm_monitor_tb_top
